// file: rtl/maac_area_access_checker.sv
/*
  area access checker between core and rom/ram/flash: checks each request, forwards
  permitted ones, answers denied ones with an error and holds per-area attributes.
  assumes core request and config strobes are on mclk_i and the memories answer on mclk_i.
*/
// Overview of operation
// [R01] every read, write, delete and execute is checked, privilege mode considered
// [R02] only privileged config writes change or lock attributes; user writes ignored
// [R03] decision uses code area, target area and operation kind
// [R04] denied access never reaches memory and returns no data
// [R05] attributes take defined defaults at reset; privileged software may override
// [R06] protection covers rom, ram and flash regions alike; rom also refuses every write and delete whatever its attributes
// [R07] attributes live in config registers reached through the config port
// [R08] every denied access raises a violation pulse to the core
`timescale 1ns/1ps
module maac_area_access_checker (
  input  wire logic                         mclk_i,
  input  wire logic                         rst_i,
  input  wire logic                         req_valid_i,
  input  wire logic [maac_pkg::AW-1:0]      req_addr_i,
  input  wire logic [1:0]                   req_op_i,
  input  wire logic                         req_priv_i,
  input  wire logic [maac_pkg::AW-1:0]      req_pc_i,
  input  wire logic [15:0]                  req_wdata_i,
  input  wire logic                         mem_rvalid_i,
  input  wire logic [15:0]                  mem_rdata_i,
  input  wire logic                         cfg_we_i,
  input  wire logic                         cfg_priv_i,
  input  wire logic [maac_pkg::IW-1:0]      cfg_idx_i,
  input  wire logic [1:0]                   cfg_field_i,
  input  wire logic [15:0]                  cfg_wdata_i,
  output logic                              resp_valid_o,
  output logic                              violation_o,
  output logic                              mem_req_o,
  output logic [maac_pkg::AW-1:0]           mem_addr_o,
  output logic [1:0]                        mem_op_o,
  output logic [2:0]                        mem_sel_o,
  output logic [15:0]                       mem_wdata_o,
  output logic                              rvalid_o,
  output logic [15:0]                       rdata_o,
  output logic [15:0]                       cfg_rdata_o,
  output logic                              cfg_ignored_o,
  output logic                              locked_o
);
  localparam int N = maac_pkg::NAREA;

  logic [maac_pkg::AW-1:0]  base_q  [N];
  logic [maac_pkg::AW-1:0]  limit_q [N];
  logic [maac_pkg::ATW-1:0] attr_q  [N];
  logic                     locked_q;

  // lowest matching area wins, so overlapping areas have a fixed priority
  function automatic logic [maac_pkg::IW-1:0] first_hit(input logic [N-1:0] hits);
    logic [maac_pkg::IW-1:0] idx;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (hits[i]) begin
        idx = maac_pkg::IW'(i);
      end
    end
    return idx;
  endfunction : first_hit

  wire [N-1:0] tgt_hit;
  wire [N-1:0] pc_hit;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_area
      assign tgt_hit[g] = (req_addr_i >= base_q[g]) && (req_addr_i <= limit_q[g]);
      assign pc_hit[g]  = (req_pc_i >= base_q[g]) && (req_pc_i <= limit_q[g]);
    end
  endgenerate

  wire [maac_pkg::IW-1:0]  tgt_idx   = first_hit(tgt_hit);
  wire [maac_pkg::IW-1:0]  pc_idx    = first_hit(pc_hit);
  wire [maac_pkg::ATW-1:0] tgt_attr  = attr_q[tgt_idx];
  // user bits sit at [3:0], privileged bits at [7:4], so the mode bit is bit 2 of the index
  wire [3:0]               perm_bit  = {1'b0, req_priv_i, req_op_i};
  wire                     op_ok     = tgt_attr[perm_bit];                          // [R01]
  wire                     caller_ok = tgt_attr[maac_pkg::ATTR_CALLER_POS + 32'(pc_idx)]; // [R03]
  wire [1:0]               map_bits  = req_addr_i[maac_pkg::AW-1 -: 2];
  wire                     is_rom    = (map_bits == maac_pkg::MAP_ROM);
  wire                     rom_mod   = is_rom && ((req_op_i == maac_pkg::MAAC_OP_WRITE) ||
                                                  (req_op_i == maac_pkg::MAAC_OP_DEL));
  wire                     allow     = (|tgt_hit) && (|pc_hit) && op_ok && caller_ok && !rom_mod; // [R03]
  wire [2:0]               sel       = is_rom ? maac_pkg::SEL_ROM :
                                       (map_bits == maac_pkg::MAP_RAM) ? maac_pkg::SEL_RAM :
                                       maac_pkg::SEL_FLASH;                          // [R06]

  wire cfg_ok  = cfg_we_i && cfg_priv_i && !locked_q;                               // [R02]
  wire cfg_ign = cfg_we_i && !cfg_ok;
  wire [15:0] cfg_rd = (cfg_field_i == maac_pkg::MAAC_FLD_BASE)  ? base_q[cfg_idx_i]  :
                       (cfg_field_i == maac_pkg::MAAC_FLD_LIMIT) ? limit_q[cfg_idx_i] :
                       (cfg_field_i == maac_pkg::MAAC_FLD_ATTR)  ? attr_q[cfg_idx_i]  :
                       {15'h0000, locked_q};

  // attribute store
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin                                             // [R05]
        base_q[i]  <= (i == 0) ? maac_pkg::RST_BASE0  : maac_pkg::RST_BASE;
        limit_q[i] <= (i == 0) ? maac_pkg::RST_LIMIT0 : maac_pkg::RST_LIMIT;
        attr_q[i]  <= (i == 0) ? maac_pkg::RST_ATTR0  : maac_pkg::RST_ATTR;
      end
      locked_q <= 1'b0;
    end else if (cfg_ok) begin                                                      // [R07]
      unique case (cfg_field_i)
        maac_pkg::MAAC_FLD_BASE:  base_q[cfg_idx_i]  <= cfg_wdata_i;
        maac_pkg::MAAC_FLD_LIMIT: limit_q[cfg_idx_i] <= cfg_wdata_i;
        maac_pkg::MAAC_FLD_ATTR:  attr_q[cfg_idx_i]  <= cfg_wdata_i;
        maac_pkg::MAAC_FLD_LOCK:  locked_q <= cfg_wdata_i[0];                       // [R02]
      endcase
    end
  end

  // request path: only permitted requests reach memory
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      resp_valid_o <= 1'b0;
      violation_o  <= 1'b0;
      mem_req_o    <= 1'b0;
      mem_addr_o   <= '0;
      mem_op_o     <= 2'h0;
      mem_sel_o    <= 3'h0;
      mem_wdata_o  <= 16'h0000;
    end else begin
      resp_valid_o <= req_valid_i;
      violation_o  <= req_valid_i && !allow;                                        // [R08]
      mem_req_o    <= req_valid_i && allow;                                         // [R04]
      mem_addr_o   <= allow ? req_addr_i : '0;
      mem_op_o     <= allow ? req_op_i : 2'h0;
      mem_sel_o    <= (req_valid_i && allow) ? sel : 3'h0;
      mem_wdata_o  <= allow ? req_wdata_i : 16'h0000;
    end
  end

  // data return and config readback
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rvalid_o      <= 1'b0;
      rdata_o       <= 16'h0000;
      cfg_rdata_o   <= 16'h0000;
      cfg_ignored_o <= 1'b0;
      locked_o      <= 1'b0;
    end else begin
      rvalid_o      <= mem_rvalid_i;
      rdata_o       <= mem_rvalid_i ? mem_rdata_i : 16'h0000;
      cfg_rdata_o   <= cfg_rd;
      cfg_ignored_o <= cfg_ign;
      locked_o      <= locked_q;
    end
  end
endmodule : maac_area_access_checker

// file: rtl/maac_pkg.sv
/*
  package of the area access checker: widths, memory map, attribute layout, defaults.
  assumes a 16-bit address space split into rom, ram and flash by the top bits.
*/
package maac_pkg;
  localparam int AW     = 16;
  localparam int NAREA  = 8;
  localparam int IW     = 3;
  localparam int ATW    = 16;

  typedef enum logic [1:0] {
    MAAC_OP_READ  = 2'h0,
    MAAC_OP_WRITE = 2'h1,
    MAAC_OP_DEL   = 2'h2,
    MAAC_OP_EXEC  = 2'h3
  } maac_op_t;

  typedef enum logic [1:0] {
    MAAC_FLD_BASE  = 2'h0,
    MAAC_FLD_LIMIT = 2'h1,
    MAAC_FLD_ATTR  = 2'h2,
    MAAC_FLD_LOCK  = 2'h3
  } maac_fld_t;

  // attribute word: [3:0] user r/w/d/x, [7:4] privileged r/w/d/x, [15:8] allowed code areas
  localparam int ATTR_PRIV_POS   = 4;
  localparam int ATTR_CALLER_POS = 8;

  // memory map by address bits 15:14
  localparam logic [1:0] MAP_ROM = 2'h0;
  localparam logic [1:0] MAP_RAM = 2'h1;
  localparam logic [2:0] SEL_ROM   = 3'h1;
  localparam logic [2:0] SEL_RAM   = 3'h2;
  localparam logic [2:0] SEL_FLASH = 3'h4;

  // reset defaults: area 0 spans everything, privileged only; other areas empty
  localparam logic [AW-1:0]  RST_BASE0  = 16'h0000;
  localparam logic [AW-1:0]  RST_LIMIT0 = 16'hFFFF;
  localparam logic [ATW-1:0] RST_ATTR0  = 16'hFFF0;
  localparam logic [AW-1:0]  RST_BASE   = 16'hFFFF;
  localparam logic [AW-1:0]  RST_LIMIT  = 16'h0000;
  localparam logic [ATW-1:0] RST_ATTR   = 16'h0000;
endpackage : maac_pkg

// file: verif/maac_area_access_checker_tb.sv
/* testbench: core requests and config writes, memory model at the far side.
   assumes maac_pkg and the design are compiled first. */
`timescale 1ns/1ps
module maac_area_access_checker_tb;
  logic        mclk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, req_priv_i = 1'b0, cfg_we_i = 1'b0;
  logic        cfg_priv_i = 1'b0, slow = 1'b0, mem_rvalid_i, resp_valid_o, violation_o, mem_req_o;
  logic        rvalid_o, cfg_ignored_o, locked_o;
  logic [1:0]  req_op_i = 2'h0, cfg_field_i = 2'h0, mem_op_o;
  logic [2:0]  cfg_idx_i = 3'h0, mem_sel_o;
  logic [15:0] req_addr_i = 16'h0000, req_pc_i = 16'h0100, req_wdata_i = 16'h0000, cfg_wdata_i = 16'h0000;
  logic [15:0] mem_rdata_i, mem_addr_o, mem_wdata_o, rdata_o, cfg_rdata_o;
  int          err_total = 0, n_compared = 0;
  maac_area_access_checker maac_area_access_checker_i (.*);
  maac_mem_model maac_mem_model_i (.mclk_i, .slow_i(slow), .req_i(mem_req_o), .op_i(mem_op_o),
    .addr_i(mem_addr_o), .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
  initial forever #2 mclk_i = ~mclk_i;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic req(input logic pv, input logic [1:0] op, input logic [15:0] ad, input logic ok);
    int n;
    req_valid_i <= 1'b1;
    req_priv_i  <= pv;
    req_op_i    <= op;
    req_addr_i  <= ad;
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    @(negedge mclk_i);
    chk(violation_o, !ok);
    chk(mem_sel_o, ok ? (ad[15] ? 3'h4 : ad[14] ? 3'h2 : 3'h1) : 3'h0);
    chk(mem_op_o, ok ? op : 2'h0);
    chk(mem_addr_o, ok ? ad : 16'h0000);
    for (n = 0; ok && op == 2'h0 && rvalid_o !== 1'b1; n++) begin
      if (n == 4) begin
        err_total++;
        test_done();
      end
      @(negedge mclk_i);
    end
    if (ok && op == 2'h0) chk(rdata_o, ~ad);
    @(posedge mclk_i);
  endtask : req
  task automatic cfg(input logic pv, input logic [1:0] f, input logic [15:0] d, input logic ign);
    cfg_we_i    <= 1'b1;
    cfg_priv_i  <= pv;
    cfg_field_i <= f;
    cfg_wdata_i <= d;
    @(posedge mclk_i);
    cfg_we_i <= 1'b0;
    @(negedge mclk_i);
    chk(cfg_ignored_o, ign);
    @(posedge mclk_i);
  endtask : cfg
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    req(1'b0, 2'h0, 16'h4000, 1'b0);
    req(1'b1, 2'h0, 16'h4000, 1'b1);
    req(1'b1, 2'h1, 16'h0010, 1'b0);
    req(1'b1, 2'h2, 16'h3000, 1'b0);
    req(1'b1, 2'h3, 16'h0040, 1'b1);
    req(1'b1, 2'h2, 16'h8000, 1'b1);
    slow <= 1'b1;
    req(1'b1, 2'h0, 16'hC000, 1'b1);
    slow <= 1'b0;
    $display("defaults done");
    cfg(1'b0, 2'h2, 16'hFFF1, 1'b1);
    req(1'b0, 2'h0, 16'h8000, 1'b0);
    cfg(1'b1, 2'h2, 16'hFFF1, 1'b0);
    @(negedge mclk_i);
    chk(cfg_rdata_o, 16'hFFF1);
    @(posedge mclk_i);
    req(1'b0, 2'h0, 16'h8000, 1'b1);
    req(1'b0, 2'h1, 16'h8000, 1'b0);
    $display("config done");
    cfg(1'b1, 2'h3, 16'h0001, 1'b0);
    @(negedge mclk_i);
    chk(locked_o, 1'b1);
    @(posedge mclk_i);
    cfg(1'b1, 2'h2, 16'hFFF0, 1'b1);
    cfg(1'b1, 2'h3, 16'h0000, 1'b1);
    req(1'b0, 2'h0, 16'h8000, 1'b1);
    $display("lock done");
    test_done();
  end
endmodule : maac_area_access_checker_tb

// file: verif/maac_mem_model.sv
/* memory model: answers forwarded reads with the inverted address.
   assumes forwarded requests on the same clock. */
`timescale 1ns/1ps
module maac_mem_model (
  input  wire logic        mclk_i,
  input  wire logic        slow_i,
  input  wire logic        req_i,
  input  wire logic [1:0]  op_i,
  input  wire logic [15:0] addr_i,
  output logic             rvalid_o = 1'b0,
  output logic [15:0]      rdata_o = 16'h0000
);
  logic        hold_q = 1'b0;
  logic [15:0] addr_q = 16'h0000;
  wire         rd = req_i && op_i == 2'h0;
  always @(posedge mclk_i) begin
    hold_q   <= rd && slow_i;
    addr_q   <= addr_i;
    rvalid_o <= (rd && !slow_i) || hold_q;
    // idle data toggles so a stale word never passes as an answer
    rdata_o  <= hold_q ? ~addr_q : (rd && !slow_i) ? ~addr_i : ~rdata_o;
  end
endmodule : maac_mem_model

// file: verif/maac_monitor.sv
/* checker of the area access checker ports.
   assumes binding into maac_area_access_checker, one clock. */
`timescale 1ns/1ps
module maac_monitor (
  input wire logic                    mclk_i,
  input wire logic                    rst_i,
  input wire logic                    req_valid_i,
  input wire logic [maac_pkg::AW-1:0] req_addr_i,
  input wire logic [1:0]              req_op_i,
  input wire logic                    cfg_we_i,
  input wire logic                    cfg_priv_i,
  input wire logic                    resp_valid_o,
  input wire logic                    violation_o,
  input wire logic                    mem_req_o,
  input wire logic [2:0]              mem_sel_o,
  input wire logic                    cfg_ignored_o,
  input wire logic                    locked_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_deny; resp_valid_o && violation_o && !mem_req_o && mem_sel_o == 3'h0; endsequence
  a_resp_next: assert property (req_valid_i |=> resp_valid_o) else $error("no answer");
  a_resp_only: assert property (!req_valid_i |=> !resp_valid_o) else $error("stray answer");
  a_deny_quiet: assert property (violation_o |-> s_deny) else $error("denied access leaks");
  a_rom_guard: assert property (req_valid_i && req_addr_i[15:14] == 2'h0 && ^req_op_i |=> s_deny) else $error("rom");
  a_user_cfg: assert property (cfg_we_i && !cfg_priv_i |=> cfg_ignored_o) else $error("user cfg");
  a_lock_holds: assert property (locked_o |=> locked_o) else $error("lock lost");
  a_fwd_onehot: assert property (mem_req_o |-> $onehot(mem_sel_o) && resp_valid_o) else $error("bad select");
  a_viol_flag: assert property (resp_valid_o && !mem_req_o |-> violation_o) else $error("no violation");
endmodule : maac_monitor
bind maac_area_access_checker maac_monitor maac_monitor_i (.mclk_i, .rst_i, .req_valid_i, .req_addr_i,
  .req_op_i, .cfg_we_i, .cfg_priv_i, .resp_valid_o, .violation_o, .mem_req_o, .mem_sel_o, .cfg_ignored_o,
  .locked_o);
